// File: logic/addr_map_defs.svh
// Address map constants for the system address decoder
`ifndef ADDR_MAP_DEFS_SVH
`define ADDR_MAP_DEFS_SVH

`define MAP_FLASH_BASE      32'h0000_0000
`define MAP_FLASH_LAST      32'h0001_7FFF
`define MAP_SRAM_BASE       32'h2000_0000
`define MAP_SRAM_LAST       32'h2000_7FFF
`define MAP_SRAM_BB_BASE    32'h2200_0000
`define MAP_SRAM_BB_LAST    32'h220F_FFFF
`define MAP_WDOG_BASE       32'h4000_0000
`define MAP_WDOG_LAST       32'h4000_0FFF
`define MAP_GPIO_LO_BASE    32'h4000_4000
`define MAP_GPIO_LO_LAST    32'h4000_7FFF
`define MAP_SSER_BASE       32'h4000_8000
`define MAP_SSER_LAST       32'h4000_8FFF
`define MAP_UART_BASE       32'h4000_C000
`define MAP_UART_LAST       32'h4000_CFFF
`define MAP_GPIO_HI_BASE    32'h4002_4000
`define MAP_GPIO_HI_LAST    32'h4002_6FFF
`define MAP_TIMER_BASE      32'h4003_0000
`define MAP_TIMER_LAST      32'h4003_2FFF
`define MAP_ADC_BASE        32'h4003_8000
`define MAP_ADC_LAST        32'h4003_8FFF
`define MAP_ACMP_BASE       32'h4003_C000
`define MAP_ACMP_LAST       32'h4003_CFFF
`define MAP_FLASHCTL_BASE   32'h400F_D000
`define MAP_FLASHCTL_LAST   32'h400F_DFFF
`define MAP_SYSCTL_BASE     32'h400F_E000
`define MAP_SYSCTL_LAST     32'h400F_EFFF
`define MAP_PERIPH_BB_BASE  32'h4200_0000
`define MAP_PERIPH_BB_LAST  32'h43FF_FFFF
`define MAP_TRACE_BASE      32'hE000_0000
`define MAP_TRACE_LAST      32'hE000_0FFF
`define MAP_WATCH_BASE      32'hE000_1000
`define MAP_WATCH_LAST      32'hE000_1FFF
`define MAP_PATCH_BASE      32'hE000_2000
`define MAP_PATCH_LAST      32'hE000_2FFF
`define MAP_CORESYS_BASE    32'hE000_E000
`define MAP_CORESYS_LAST    32'hE000_EFFF
`define MAP_TPORT_BASE      32'hE004_0000
`define MAP_TPORT_LAST      32'hE004_0FFF
`define MAP_PERIPH_BB_UNDER 32'h4000_0000
`define SLOT_LSB            12
`define BB_BIT_LSB          2
`define BB_BYTE_LSB         5
`define BB_OFFSET_W         25

`endif

// File: logic/addr_map_pkg.sv
// Types shared by the system address decoder and its lookup
package addr_map_pkg;

   typedef enum logic [4:0] {
      tgt_none,
      tgt_flash,
      tgt_sram,
      tgt_sram_alias,
      tgt_watchdog,
      tgt_gpio_low,
      tgt_sync_serial,
      tgt_uart,
      tgt_gpio_high,
      tgt_timer,
      tgt_analog_sampler,
      tgt_comparator,
      tgt_flash_ctrl,
      tgt_system_ctrl,
      tgt_periph_alias,
      tgt_instrumentation_trace_unit,
      tgt_data_watchpoint_unit,
      tgt_patch_breakpoint_unit,
      tgt_core_system,
      tgt_trace_port_unit
   } target_e;

   typedef enum logic [1:0] {
      size_byte,
      size_half,
      size_word
   } size_e;

   typedef enum logic [1:0] {
      st_idle,
      st_xfer,
      st_bb_read,
      st_bb_write
   } fsm_e;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      size_e       size;
      logic [31:0] wdata;
   } req_s;

   typedef struct packed {
      logic [31:0] rdata;
      logic        fault;
   } resp_s;

   typedef struct packed {
      target_e     sel;
      logic [1:0]  unit;
      logic [31:0] offset;
      logic        write;
      logic        lock;
      logic [3:0]  be;
      logic [31:0] wdata;
   } tgt_s;

   typedef struct packed {
      logic        hit;
      target_e     sel;
      logic [1:0]  unit;
      logic [31:0] offset;
      logic        bit_alias;
   } decode_s;

endpackage

// File: logic/region_lookup.sv
// Table lookup of one address against the fixed system map
`timescale 1ns/1ns
`include "addr_map_defs.svh"

module region_lookup
   import addr_map_pkg::*;
(
   // Address to decode
   input  wire logic [31:0] addr,
   // Decode result
   output decode_s          dec
);

   localparam int N = 19;

   localparam logic [31:0] BASE [N] = '{
      `MAP_FLASH_BASE, `MAP_SRAM_BASE, `MAP_SRAM_BB_BASE, `MAP_WDOG_BASE,
      `MAP_GPIO_LO_BASE, `MAP_SSER_BASE, `MAP_UART_BASE, `MAP_GPIO_HI_BASE,
      `MAP_TIMER_BASE, `MAP_ADC_BASE, `MAP_ACMP_BASE, `MAP_FLASHCTL_BASE,
      `MAP_SYSCTL_BASE, `MAP_PERIPH_BB_BASE, `MAP_TRACE_BASE, `MAP_WATCH_BASE,
      `MAP_PATCH_BASE, `MAP_CORESYS_BASE, `MAP_TPORT_BASE};

   localparam logic [31:0] LAST [N] = '{
      `MAP_FLASH_LAST, `MAP_SRAM_LAST, `MAP_SRAM_BB_LAST, `MAP_WDOG_LAST,
      `MAP_GPIO_LO_LAST, `MAP_SSER_LAST, `MAP_UART_LAST, `MAP_GPIO_HI_LAST,
      `MAP_TIMER_LAST, `MAP_ADC_LAST, `MAP_ACMP_LAST, `MAP_FLASHCTL_LAST,
      `MAP_SYSCTL_LAST, `MAP_PERIPH_BB_LAST, `MAP_TRACE_LAST, `MAP_WATCH_LAST,
      `MAP_PATCH_LAST, `MAP_CORESYS_LAST, `MAP_TPORT_LAST};

   localparam target_e SEL [N] = '{
      tgt_flash, tgt_sram, tgt_sram_alias, tgt_watchdog,
      tgt_gpio_low, tgt_sync_serial, tgt_uart, tgt_gpio_high,
      tgt_timer, tgt_analog_sampler, tgt_comparator, tgt_flash_ctrl,
      tgt_system_ctrl, tgt_periph_alias, tgt_instrumentation_trace_unit,
      tgt_data_watchpoint_unit, tgt_patch_breakpoint_unit, tgt_core_system,
      tgt_trace_port_unit};

   logic [N-1:0] hit_vec;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_cmp
         assign hit_vec[i] = (addr >= BASE[i]) && (addr <= LAST[i]);
      end
   endgenerate

   // Ranges never overlap, so at most one entry hits
   always_comb begin
      logic [31:0] off;
      off           = '0;
      dec.hit       = 1'b0;
      dec.sel       = tgt_none;
      dec.unit      = 2'h0;
      dec.offset    = '0;
      dec.bit_alias = 1'b0;
      for (int k = 0; k < N; k++) begin
         if (hit_vec[k]) begin
            dec.hit = 1'b1;
            dec.sel = SEL[k];
            off     = addr - BASE[k];
         end
      end
      // Grouped ports and timers share one entry; the slot number picks the unit
      if (dec.sel == tgt_gpio_low || dec.sel == tgt_gpio_high || dec.sel == tgt_timer) begin
         dec.unit   = off[`SLOT_LSB+1:`SLOT_LSB];
         dec.offset = {20'h0_0000, off[`SLOT_LSB-1:0]};
      end else begin
         dec.offset = off;
      end
      dec.bit_alias = (dec.sel == tgt_sram_alias) || (dec.sel == tgt_periph_alias);
   end

endmodule

// File: logic/system_address_decoder.sv
// Decoder that steers processor accesses across the fixed system map
`timescale 1ns/1ns
`include "addr_map_defs.svh"

// How it works
// - Fixed 32-bit map, never changes
// - Reserved addresses end in bus fault
// - Low addresses select on-chip flash
// - SRAM window, rest up to alias reserved
// - SRAM alias window decodes to SRAM bits
// - Watchdog takes first peripheral slot
// - Four low GPIO ports, one slot each
// - Three high GPIO ports, one slot each
// - Three timers in consecutive slots
// - Comparator module takes its own slot
// - Flash controller registers slot decode
// - System control registers slot decode
// - Peripheral alias window maps peripheral bits
// - Trace, watchpoint, breakpoint units private slots
// - Core system peripherals share one slot
// - Trace port unit slot, rest reserved
// - All accesses use little-endian byte order
// - Word, halfword, byte transfers by lanes
// - Targets see offset from their base
module system_address_decoder
   import addr_map_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // Processor request
   input  wire logic        req_valid,
   input  req_s             req,
   output logic             req_ready,
   // Processor answer
   output logic             resp_valid,
   output resp_s            resp,
   // Target command
   output logic             tgt_valid,
   output tgt_s             tgt,
   // Target answer
   input  wire logic        tgt_done,
   input  wire logic [31:0] tgt_rdata,
   input  wire logic        tgt_err
);

   typedef struct packed {
      fsm_e       st;
      logic       resp_valid;
      resp_s      resp;
      logic       tgt_valid;
      tgt_s       tgt;
      size_e      size;
      logic [1:0] lane;
      logic       bb_write;
      logic       bb_val;
      logic [4:0] bb_bit;
   } state_s;

   state_s q, d;

   decode_s req_dec;
   decode_s bb_dec;

   logic [`BB_OFFSET_W-1:0] bb_off;
   logic [31:0]             bb_byte_addr;
   logic [31:0]             bb_word_addr;
   logic [4:0]              bb_bit;

   // Byte strobes from size and low address bits
   function automatic logic [3:0] lane_strobe(input size_e sz, input logic [1:0] lane);
      logic [3:0] be;
      be = 4'hF;
      case (sz)
         size_byte: be = 4'h1 << lane;
         size_half: be = lane[1] ? 4'hC : 4'h3;
         default:   be = 4'hF;
      endcase
      return be;
   endfunction

   // Write data spread over every lane the size can use
   function automatic logic [31:0] lane_spread(input size_e sz, input logic [31:0] w);
      logic [31:0] r;
      r = w;
      case (sz)
         size_byte: r = {4{w[7:0]}};
         size_half: r = {2{w[15:0]}};
         default:   r = w;
      endcase
      return r;
   endfunction

   // Lowest lane holds the lowest address byte
   function automatic logic [31:0] lane_pick(input size_e sz, input logic [1:0] lane,
                                            input logic [31:0] w);
      logic [31:0] s;
      logic [31:0] r;
      s = w >> {lane, 3'b000};
      r = s;
      case (sz)
         size_byte: r = {24'h00_0000, s[7:0]};
         size_half: r = {16'h0000, s[15:0]};
         default:   r = s;
      endcase
      return r;
   endfunction

   // Halfwords and words must sit on their natural boundary
   function automatic logic misaligned(input size_e sz, input logic [1:0] lane);
      logic m;
      m = 1'b0;
      case (sz)
         size_byte: m = 1'b0;
         size_half: m = lane[0];
         default:   m = |lane;
      endcase
      return m;
   endfunction

   // Request address against the full map
   region_lookup u_req_lookup (
      .addr (req.addr),
      .dec  (req_dec)
   );

   // Each alias word names one bit of a byte in the region beneath
   assign bb_off       = req_dec.offset[`BB_OFFSET_W-1:0];
   assign bb_byte_addr = ((req_dec.sel == tgt_sram_alias) ? `MAP_SRAM_BASE
                                                          : `MAP_PERIPH_BB_UNDER)
                         + {12'h000, bb_off[`BB_OFFSET_W-1:`BB_BYTE_LSB]};
   assign bb_word_addr = {bb_byte_addr[31:2], 2'b00};
   assign bb_bit       = {bb_byte_addr[1:0], bb_off[`BB_BYTE_LSB-1:`BB_BIT_LSB]};

   // Underlying word is decoded again; a hole beneath the alias still faults
   region_lookup u_bb_lookup (
      .addr (bb_word_addr),
      .dec  (bb_dec)
   );

   // New requests only while no transfer is open
   assign req_ready = ce && (q.st == st_idle);

   assign resp_valid = q.resp_valid;
   assign resp       = q.resp;
   assign tgt_valid  = q.tgt_valid;
   assign tgt        = q.tgt;

   always_comb begin
      logic [31:0] merged;
      merged = tgt_rdata;
      d = q;
      d.resp_valid = 1'b0;

      case (q.st)
         st_idle: begin
            if (req_valid) begin
               d.size = req.size;
               d.lane = req.addr[1:0];
               if (!req_dec.hit) begin
                  // Holes in the map answer with a fault, never data
                  d.resp_valid = 1'b1;
                  d.resp.fault = 1'b1;
                  d.resp.rdata = '0;
               end else if (req_dec.bit_alias) begin
                  if (!bb_dec.hit || bb_dec.bit_alias) begin
                     d.resp_valid = 1'b1;
                     d.resp.fault = 1'b1;
                     d.resp.rdata = '0;
                  end else begin
                     // Read the whole word first, bus held locked until done
                     d.bb_write      = req.write;
                     d.bb_val        = req.wdata[0];
                     d.bb_bit        = bb_bit;
                     d.tgt_valid     = 1'b1;
                     d.tgt.sel       = bb_dec.sel;
                     d.tgt.unit      = bb_dec.unit;
                     d.tgt.offset    = bb_dec.offset;
                     d.tgt.write     = 1'b0;
                     d.tgt.lock      = 1'b1;
                     d.tgt.be        = 4'hF;
                     d.tgt.wdata     = '0;
                     d.st            = st_bb_read;
                  end
               end else if (misaligned(req.size, req.addr[1:0])) begin
                  d.resp_valid = 1'b1;
                  d.resp.fault = 1'b1;
                  d.resp.rdata = '0;
               end else begin
                  d.tgt_valid  = 1'b1;
                  d.tgt.sel    = req_dec.sel;
                  d.tgt.unit   = req_dec.unit;
                  d.tgt.offset = req_dec.offset;
                  d.tgt.write  = req.write;
                  d.tgt.lock   = 1'b0;
                  d.tgt.be     = lane_strobe(req.size, req.addr[1:0]);
                  d.tgt.wdata  = lane_spread(req.size, req.wdata);
                  d.st         = st_xfer;
               end
            end
         end

         st_xfer: begin
            if (tgt_done) begin
               d.tgt_valid  = 1'b0;
               d.resp_valid = 1'b1;
               d.resp.fault = tgt_err;
               d.resp.rdata = (q.tgt.write || tgt_err) ? 32'h0000_0000
                              : lane_pick(q.size, q.lane, tgt_rdata);
               d.st         = st_idle;
            end
         end

         st_bb_read: begin
            if (tgt_done) begin
               if (tgt_err) begin
                  d.tgt_valid  = 1'b0;
                  d.tgt.lock   = 1'b0;
                  d.resp_valid = 1'b1;
                  d.resp.fault = 1'b1;
                  d.resp.rdata = '0;
                  d.st         = st_idle;
               end else if (q.bb_write) begin
                  // Only the chosen bit changes; the rest is written back as read
                  merged[q.bb_bit] = q.bb_val;
                  d.tgt.write      = 1'b1;
                  d.tgt.wdata      = merged;
                  d.st             = st_bb_write;
               end else begin
                  d.tgt_valid  = 1'b0;
                  d.tgt.lock   = 1'b0;
                  d.resp_valid = 1'b1;
                  d.resp.fault = 1'b0;
                  d.resp.rdata = {31'h0000_0000, tgt_rdata[q.bb_bit]};
                  d.st         = st_idle;
               end
            end
         end

         st_bb_write: begin
            if (tgt_done) begin
               d.tgt_valid  = 1'b0;
               d.tgt.lock   = 1'b0;
               d.tgt.write  = 1'b0;
               d.resp_valid = 1'b1;
               d.resp.fault = tgt_err;
               d.resp.rdata = '0;
               d.st         = st_idle;
            end
         end

         default: begin
            d.st        = st_idle;
            d.tgt_valid = 1'b0;
            d.tgt.lock  = 1'b0;
         end
      endcase
   end

   // Map is fixed in the lookup tables; no state can alter it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // All-zero is idle, byte size and no target
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

endmodule

// File: testbench/system_address_decoder_properties.sv
// Timing and decode properties of the system address decoder
`timescale 1ns/1ns
module system_address_decoder_properties
   import addr_map_pkg::*;
(
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   // Processor side
   input wire logic        req_valid,
   input req_s             req,
   input wire logic        req_ready,
   input wire logic        resp_valid,
   input resp_s            resp,
   // Target side
   input wire logic        tgt_valid,
   input tgt_s             tgt,
   input wire logic        tgt_done,
   input wire logic [31:0] tgt_rdata,
   input wire logic        tgt_err
);
   logic take;
   assign take = req_valid && req_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   a_top_hole: assert property (take && req.addr[31:28] == 4'hF
      |=> resp_valid && resp.fault && !tgt_valid) else $error("top hole not faulted");
   a_flash_hole: assert property (take && req.addr inside {[32'h0001_8000:32'h1FFF_FFFF]}
      |=> resp_valid && resp.fault) else $error("flash hole not faulted");
   a_sram_sel: assert property (take && req.addr[1:0] == 2'h0
      && req.addr inside {[32'h2000_0000:32'h2000_7FFF]}
      |=> tgt_valid && tgt.sel == tgt_sram && tgt.offset == $past(req.addr) - 32'h2000_0000)
      else $error("sram command wrong");
   a_byte_lanes: assert property (take && req.write && req.size == size_byte
      && req.addr inside {[32'h2000_0000:32'h2000_7FFF]}
      |=> tgt.be == 4'h1 << $past(req.addr[1:0]) && tgt.wdata == {4{$past(req.wdata[7:0])}})
      else $error("byte lanes wrong");
   a_gpio_slot: assert property (take && req.addr[1:0] == 2'h0
      && req.addr inside {[32'h4000_4000:32'h4000_7FFF]}
      |=> tgt.sel == tgt_gpio_low && tgt.unit == $past(req.addr[13:12])
      && tgt.offset == {20'h0, $past(req.addr[11:0])}) else $error("gpio slot wrong");
   a_alias_read: assert property (take && req.addr inside {[32'h2200_0000:32'h220F_FFFF]}
      |=> tgt_valid && tgt.lock && !tgt.write && tgt.sel == tgt_sram
      && tgt.offset == {17'h0, $past(req.addr[19:7]), 2'b00}) else $error("alias read wrong");
   a_hold_cmd: assert property (tgt_valid && !tgt_done
      |=> tgt_valid && $stable(tgt)) else $error("command changed while open");
   a_end_answer: assert property (tgt_valid && tgt_done && !tgt.lock
      |=> resp_valid && !tgt_valid && resp.fault == $past(tgt_err)) else $error("answer wrong");
   a_bb_finish: assert property (tgt_valid && tgt.lock && tgt.write && tgt_done
      |=> resp_valid && !tgt_valid && !tgt.lock) else $error("alias write not closed");
endmodule

bind system_address_decoder system_address_decoder_properties chk (.clk(clk), .nrst(nrst),
   .ce(ce), .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
   .resp(resp), .tgt_valid(tgt_valid), .tgt(tgt), .tgt_done(tgt_done),
   .tgt_rdata(tgt_rdata), .tgt_err(tgt_err));

// File: testbench/target_model.sv
// Target responder with random wait states and a word memory
`timescale 1ns/1ns
module target_model
   import addr_map_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Command
   input  wire logic        tgt_valid,
   input  tgt_s             tgt,
   input  wire logic        err_req,
   // Completion
   output logic             tgt_done,
   output logic [31:0]      tgt_rdata,
   output logic             tgt_err
);
   logic [31:0] mem [logic [36:0]];
   logic [31:0] word;
   logic [1:0]  wait_q;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tgt_done  <= 1'b0;
         tgt_rdata <= 32'h0;
         tgt_err   <= 1'b0;
         wait_q    <= 2'h0;
      end else if (tgt_valid && !tgt_done && wait_q == 2'h0) begin
         word = mem.exists({tgt.sel, tgt.unit, tgt.offset[31:2]}) ?
            mem[{tgt.sel, tgt.unit, tgt.offset[31:2]}] : 32'h0;
         for (int i = 0; i < 4; i++) begin
            if (tgt.write && tgt.be[i]) word[8*i +: 8] = tgt.wdata[8*i +: 8];
         end
         mem[{tgt.sel, tgt.unit, tgt.offset[31:2]}] = word;
         tgt_done  <= 1'b1;
         tgt_rdata <= word;
         tgt_err   <= err_req;
         wait_q    <= 2'($urandom_range(3));
      end else begin
         // Lines keep moving outside a completion so stale answers cannot pass
         tgt_done  <= 1'b0;
         tgt_rdata <= ~tgt_rdata;
         tgt_err   <= ~tgt_err;
         if (tgt_valid && !tgt_done) wait_q <= wait_q - 2'h1;
      end
   end
endmodule

// File: testbench/tb_system_address_decoder.sv
// Self-checking bench for the system address decoder
`timescale 1ns/1ns
module tb_system_address_decoder import addr_map_pkg::*;;
   logic        clk;
   logic        nrst;
   logic        ce;
   logic        req_valid;
   logic        req_ready;
   logic        resp_valid;
   logic        tgt_valid;
   logic        tgt_done;
   logic        tgt_err;
   logic        err_req;
   logic [31:0] tgt_rdata;
   req_s        req;
   resp_s       resp;
   tgt_s        tgt;
   tgt_s        cap;
   logic        cap_seen;
   logic [31:0] rd;
   logic        flt;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;

   localparam logic [31:0] lo_t [17] = '{32'h0000_0000, 32'h2000_0000, 32'h4000_0000,
      32'h4000_4000, 32'h4000_8000, 32'h4000_C000, 32'h4002_4000, 32'h4003_0000,
      32'h4003_8000, 32'h4003_C000, 32'h400F_D000, 32'h400F_E000, 32'hE000_0000,
      32'hE000_1000, 32'hE000_2000, 32'hE000_E000, 32'hE004_0000};
   localparam logic [31:0] sp_t [17] = '{32'h1_7FFF, 32'h7FFF, 32'hFFF, 32'h3FFF, 32'hFFF,
      32'hFFF, 32'h2FFF, 32'h2FFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF,
      32'hFFF, 32'hFFF, 32'hFFF};
   localparam target_e sel_t [17] = '{tgt_flash, tgt_sram, tgt_watchdog, tgt_gpio_low,
      tgt_sync_serial, tgt_uart, tgt_gpio_high, tgt_timer, tgt_analog_sampler,
      tgt_comparator, tgt_flash_ctrl, tgt_system_ctrl, tgt_instrumentation_trace_unit,
      tgt_data_watchpoint_unit, tgt_patch_breakpoint_unit, tgt_core_system,
      tgt_trace_port_unit};
   localparam logic [31:0] hole_t [19] = '{32'h0001_8000, 32'h1FFF_FFFC, 32'h2000_8000,
      32'h2210_0000, 32'h3FFF_FFFC, 32'h4000_1000, 32'h4000_9000, 32'h4000_D000,
      32'h4002_0000, 32'h4002_7000, 32'h4003_3000, 32'h4003_D000, 32'h400F_F000,
      32'h4202_0000, 32'h4400_0000, 32'hE000_3000, 32'hE000_F000, 32'hE004_1000,
      32'hFFFF_FFFC};

   system_address_decoder uut (.clk(clk), .nrst(nrst), .ce(ce), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
      .tgt_valid(tgt_valid), .tgt(tgt), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata),
      .tgt_err(tgt_err));
   target_model far_end (.clk(clk), .nrst(nrst), .tgt_valid(tgt_valid), .tgt(tgt),
      .err_req(err_req), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata), .tgt_err(tgt_err));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         results();
      end
   end

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One processor access; held until taken, then released with every request bit inverted
   task automatic xfer(input logic [31:0] a, input logic w, input size_e s, input logic [31:0] d);
      int n;
      @(negedge clk);
      req_valid = 1'b1;
      req = '{a, w, s, d};
      cap_seen = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      req = ~req;
      while (resp_valid !== 1'b1 && n < 100) begin
         if (tgt_valid === 1'b1 && !cap_seen) begin
            cap = tgt;
            cap_seen = 1'b1;
         end
         @(negedge clk);
         n++;
      end
      rd = resp.rdata;
      flt = resp.fault;
      if (n >= 100) check(80'h0, 80'h1);
   endtask

   // Alias word of bit b in the word at ab's region plus off: 32 alias bytes per byte
   function automatic logic [31:0] alias_addr(input logic [31:0] ab, input logic [31:0] off,
                                             input int b);
      return ab + (off << 5) + (32'(b) << 2);
   endfunction

   initial begin
      logic [31:0] a;
      logic [31:0] d;
      logic [31:0] off;
      logic [31:0] ub;
      logic [31:0] ab;
      logic        v;
      int          b;
      tgt_s        e;
      nrst = 1'b0;
      ce = 1'b1;
      req_valid = 1'b0;
      req = '0;
      err_req = 1'b0;
      d = $urandom(32'h349B);
      repeat (3) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      check({resp_valid, tgt_valid, req_ready}, 3'b001);
      ce = 1'b0;
      @(negedge clk);
      check(req_ready, 1'b0);
      ce = 1'b1;
      for (int i = 0; i < 17; i++) begin
         for (int k = 0; k < 3; k++) begin
            off = k == 0 ? 32'h0 : k == 1 ? sp_t[i] - 32'h3 : $urandom_range(sp_t[i]) & ~32'h3;
            a = lo_t[i] + off;
            d = $urandom;
            e = '0;
            e.sel = sel_t[i];
            e.offset = off;
            // Grouped modules see a unit number and an offset inside the slot
            if (sel_t[i] inside {tgt_gpio_low, tgt_gpio_high, tgt_timer}) begin
               e.unit = off[13:12];
               e.offset = {20'h0, off[11:0]};
            end
            e.write = 1'b1;
            e.be = 4'hF;
            e.wdata = d;
            xfer(a, 1'b1, size_word, d);
            check({cap, flt}, {e, 1'b0});
            xfer(a, 1'b0, size_word, $urandom);
            check({flt, rd}, {1'b0, d});
         end
      end
      foreach (hole_t[i]) begin
         xfer(hole_t[i], i[0], size_word, $urandom);
         check({cap_seen, flt, rd}, {2'b01, 32'h0});
      end
      for (int j = 1; j < 3; j++) begin
         xfer(32'h2000_0000 + j, 1'b0, j == 1 ? size_half : size_word, 32'h0);
         check(flt, 1'b1);
      end
      a = 32'h2000_0100;
      d = $urandom;
      xfer(a, 1'b1, size_word, d);
      for (int j = 0; j < 4; j++) begin
         xfer(a + j, 1'b0, size_byte, 32'h0);
         check(rd, (d >> (8 * j)) & 32'hFF);
         xfer(a + (j & 2), 1'b0, size_half, 32'h0);
         check(rd, (d >> (8 * (j & 2))) & 32'hFFFF);
         xfer(a + j, 1'b1, size_byte, 32'($urandom_range(255)) + 32'hA500);
         d[8*j +: 8] = req[7:0] ^ 8'hFF;
      end
      off = $urandom;
      xfer(a + 32'h2, 1'b1, size_half, off);
      d[31:16] = off[15:0];
      xfer(a, 1'b0, size_word, 32'h0);
      check(rd, d);
      for (int k = 0; k < 8; k++) begin
         ub = k[0] ? 32'h4000_0000 : 32'h2000_0000;
         ab = k[0] ? 32'h4200_0000 : 32'h2200_0000;
         off = k[0] ? 32'h000F_E000 + ($urandom_range(32'h3FF) << 2)
                    : $urandom_range(32'h1FFF) << 2;
         b = $urandom_range(31);
         v = 1'($urandom);
         d = $urandom;
         xfer(ub + off, 1'b1, size_word, d);
         xfer(alias_addr(ab, off, b), 1'b1, size_byte, {31'($urandom), v});
         check({flt, rd}, {1'b0, 32'h0});
         d[b] = v;
         xfer(ub + off, 1'b0, size_word, 32'h0);
         check(rd, d);
         xfer(alias_addr(ab, off, b), 1'b0, size_word, 32'h0);
         check({flt, rd}, {1'b0, 31'h0, v});
      end
      err_req = 1'b1;
      xfer(32'h2000_0008, 1'b0, size_word, 32'h0);
      check(flt, 1'b1);
      xfer(32'h2200_0100, 1'b0, size_word, 32'h0);
      check(flt, 1'b1);
      err_req = 1'b0;
      results();
   end
endmodule
